// [hw/amc_cmd_handler.sv]
// Task-file command handler for multiple mode, power, no-op and buffer commands.
`timescale 1ns/1ns
`include "amc_params.svh"
module amc_cmd_handler import amc_pkg::*; #(
    parameter int         TICK_CYCLES = `AMC_TICK_CYC,
    parameter int         IDLE_TICKS  = `AMC_IDLE_TICKS,
    parameter logic [7:0] MAX_BLOCK   = 8'h01,
    parameter logic       DEV_SEL     = 1'b0,
    parameter int         BUF_WORDS   = `AMC_BUF_WORDS
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wrData,
    input  wire logic        wrStb,
    input  wire logic        rdStb,
    output logic      [15:0] rdData,
    output logic             irq,
    output logic             busy,
    output logic             drq,
    output logic             sleepMode,
    output logic             multiEnable
);
    localparam int AW = $clog2(BUF_WORDS);

    amc_state_t    state;
    amc_taskfile_t tf;
    amc_events_t   evt;
    amc_events_t   intStat;
    amc_events_t   intMask;
    amc_events_t   next_intStat;
    logic [7:0]    cmd;
    logic [7:0]    blockSize;
    logic          errAbort;
    logic [AW-1:0] bufPtr;
    logic [AW-1:0] rdPtr;
    logic [15:0]   memQ;
    logic          idleExpire;
    logic          next_abort;
    logic          next_multi;
    logic [7:0]    next_block;
    logic          goSleep;
    logic          cmdWr;
    logic          devMatch;
    logic          cmdTake;
    logic          exec;
    logic          dataWr;
    logic          lastWord;

    // Returns high for every opcode that puts the card to sleep.
    function automatic logic isSleepOp(input logic [7:0] op);
        isSleepOp = (op == `AMC_OP_SLEEP_A) || (op == `AMC_OP_SLEEP_B) ||
                    (op == `AMC_OP_STBY_A)  || (op == `AMC_OP_STBY_B)  ||
                    (op == `AMC_OP_STBI_A)  || (op == `AMC_OP_STBI_B);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Command acceptance.

    // Commands are taken only when idle and addressed to this drive.
    assign cmdWr    = ce && wrStb && (addr == `AMC_A_CMD);
    assign devMatch = (tf.driveHead[`AMC_DH_DEV] == DEV_SEL); // RULE_15
    assign cmdTake  = cmdWr && (state == AMC_IDLE) && devMatch;
    assign exec     = ce && (state == AMC_EXEC);
    assign dataWr   = ce && wrStb && (addr == `AMC_A_DATA) && (state == AMC_XFER);
    assign lastWord = dataWr && (bufPtr == AW'(BUF_WORDS - 1));

    // Command state machine.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= AMC_IDLE;
        end else if (ce) begin
            case (state)
                AMC_IDLE: begin
                    if (cmdTake) begin
                        state <= AMC_EXEC;
                    end
                end
                AMC_EXEC: begin
                    state <= (cmd == `AMC_OP_WBUF) ? AMC_XFER : AMC_IDLE;
                end
                AMC_XFER: begin
                    if (lastWord) begin
                        state <= AMC_IDLE; // RULE_14
                    end
                end
                default: begin
                    state <= AMC_IDLE;
                end
            endcase
        end
    end

    // Latches the opcode of a taken command.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd <= 8'h00;
        end else if (cmdTake) begin
            cmd <= wrData[7:0];
        end
    end

    // Busy rises with the command and falls when execution finishes.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            drq  <= 1'b0;
        end else if (ce) begin
            if (cmdTake) begin
                busy <= 1'b1; // RULE_01
            end else if (state == AMC_EXEC) begin
                busy <= 1'b0;
                drq  <= (cmd == `AMC_OP_WBUF);
            end else if (lastWord) begin
                drq <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode.

    // Works out the outcome of the latched command from defined fields only.
    always_comb begin
        next_abort = 1'b0;
        next_multi = multiEnable;
        next_block = blockSize;
        goSleep    = isSleepOp(cmd); // RULE_06 RULE_10 RULE_11
        case (cmd)
            `AMC_OP_SETMULT: begin
                if (tf.secCount == 8'h00) begin
                    next_multi = 1'b0; // RULE_04
                end else if (tf.secCount <= MAX_BLOCK) begin
                    next_multi = 1'b1; // RULE_02
                    next_block = tf.secCount;
                end else begin
                    next_abort = 1'b1; // RULE_03
                    next_multi = 1'b0;
                end
            end
            `AMC_OP_SMART: begin
                next_abort = (tf.cylHigh != `AMC_SMART_HI) ||
                             (tf.cylLow != `AMC_SMART_LO); // RULE_09
            end
            `AMC_OP_XLATE, `AMC_OP_WEAR, `AMC_OP_WBUF: next_abort = 1'b0;
            default: next_abort = !goSleep; // Unknown opcodes are refused.
        endcase
    end

    // Keeps the multiple-mode setting and the abort flag of the last command.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            multiEnable <= 1'b0; // RULE_05
            blockSize   <= 8'h00;
            errAbort    <= 1'b0;
        end else if (exec) begin
            multiEnable <= next_multi;
            blockSize   <= next_block;
            errAbort    <= next_abort;
        end
    end

    // Sleep is left on any taken command and entered by command or idle timer.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sleepMode <= 1'b0;
        end else if (ce) begin
            if (cmdTake) begin
                sleepMode <= 1'b0; // RULE_07
            end else if ((exec && goSleep) || idleExpire) begin
                sleepMode <= 1'b1; // RULE_08
            end
        end
    end

    amc_idle_timer #(
        .TICK_CYCLES (TICK_CYCLES),
        .IDLE_TICKS  (IDLE_TICKS)
    ) u_timer (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .restart (wrStb || rdStb),
        .run     ((state == AMC_IDLE) && !sleepMode),
        .expire  (idleExpire)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Task file and sector buffer.

    // Host writes task-file fields while idle; no-op commands zero the count.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tf <= '0;
        end else if (ce) begin
            if (exec && ((cmd == `AMC_OP_XLATE) || (cmd == `AMC_OP_WEAR))) begin
                tf.secCount <= 8'h00; // RULE_12 RULE_13
            end else if (wrStb && (state == AMC_IDLE)) begin
                case (addr)
                    `AMC_A_FEAT:   tf.feature   <= wrData[7:0];
                    `AMC_A_SECCNT: tf.secCount  <= wrData[7:0];
                    `AMC_A_SECNUM: tf.secNum    <= wrData[7:0];
                    `AMC_A_CYLLO:  tf.cylLow    <= wrData[7:0];
                    `AMC_A_CYLHI:  tf.cylHigh   <= wrData[7:0];
                    `AMC_A_DRVHD:  tf.driveHead <= wrData[7:0];
                    default:       tf.feature   <= tf.feature;
                endcase
            end
        end
    end

    // Both buffer pointers restart with each command; the read pointer steps on idle data reads.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bufPtr <= '0;
            rdPtr  <= '0;
        end else if (ce) begin
            if (cmdTake) begin
                bufPtr <= '0;
                rdPtr  <= '0;
            end else begin
                if (dataWr) begin
                    bufPtr <= bufPtr + 1'b1; // RULE_14
                end
                if (rdStb && (addr == `AMC_A_DATA) && (state == AMC_IDLE)) begin
                    rdPtr <= rdPtr + 1'b1;
                end
            end
        end
    end

    amc_sector_mem #(
        .DW    (16),
        .DEPTH (BUF_WORDS)
    ) u_buf (
        .ref_clk (ref_clk),
        .ce      (ce),
        .wrEn    (dataWr),
        .wrAddr  (bufPtr),
        .wrData  (wrData),
        .rdAddr  (rdPtr),
        .rdData  (memQ)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts and read port.

    // Event pulses derived from the command flow.
    assign evt.done    = (exec && (cmd != `AMC_OP_WBUF)) || lastWord;
    assign evt.abort   = exec && next_abort;
    assign evt.sleep   = ce && !sleepMode && ((exec && goSleep) || idleExpire) && !cmdTake;
    assign evt.bufFull = lastWord;

    // Sticky status bits: a set in the same cycle beats the write-one clear.
    always_comb begin
        next_intStat = intStat;
        if (ce && wrStb && (addr == `AMC_A_INTSTAT)) begin
            next_intStat = intStat & ~amc_events_t'(wrData[3:0]);
        end
        next_intStat = next_intStat | evt;
    end

    // Interrupt status, mask and the level interrupt output.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            intStat <= '0;
            intMask <= '0;
            irq     <= 1'b0;
        end else if (ce) begin
            intStat <= next_intStat;
            if (wrStb && (addr == `AMC_A_INTMASK)) begin
                intMask <= amc_events_t'(wrData[3:0]);
            end
            irq <= |(next_intStat & intMask);
        end
    end

    // Read data stand for one cycle after the strobe, zero otherwise.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= 16'h0000;
        end else if (ce) begin
            rdData <= 16'h0000;
            if (rdStb) begin
                case (addr)
                    `AMC_A_DATA:    rdData <= memQ;
                    `AMC_A_FEAT:    rdData <= {13'h0000, errAbort, 2'h0};
                    `AMC_A_SECCNT:  rdData <= {8'h00, tf.secCount};
                    `AMC_A_SECNUM:  rdData <= {8'h00, tf.secNum};
                    `AMC_A_CYLLO:   rdData <= {8'h00, tf.cylLow};
                    `AMC_A_CYLHI:   rdData <= {8'h00, tf.cylHigh};
                    `AMC_A_DRVHD:   rdData <= {8'h00, tf.driveHead};
                    `AMC_A_CMD:     rdData <= {8'h00, busy, !busy, 2'h0, drq, 2'h0, errAbort};
                    `AMC_A_INTSTAT: rdData <= {12'h000, intStat};
                    `AMC_A_INTMASK: rdData <= {12'h000, intMask};
                    `AMC_A_MULTI:   rdData <= {7'h00, multiEnable, blockSize};
                    `AMC_A_IDENT82: rdData <= `AMC_IDENT82; // RULE_09
                    default:        rdData <= 16'h0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    property p_busy_on_cmd;
        cmdTake |=> busy && (state == AMC_EXEC);
    endproperty
    a_busy_on_cmd: assert property (p_busy_on_cmd) else $error("busy not set"); // RULE_01

    property p_multi_ok;
        exec && (cmd == `AMC_OP_SETMULT) && (tf.secCount != 8'h00) && (tf.secCount <= MAX_BLOCK)
            |=> multiEnable && (blockSize == $past(tf.secCount)) && !errAbort;
    endproperty
    a_multi_ok: assert property (p_multi_ok) else $error("block count not stored"); // RULE_02

    property p_multi_bad;
        exec && (cmd == `AMC_OP_SETMULT) && (tf.secCount > MAX_BLOCK)
            |=> !multiEnable && errAbort && intStat.abort;
    endproperty
    a_multi_bad: assert property (p_multi_bad) else $error("bad count not aborted"); // RULE_03

    property p_multi_zero;
        exec && (cmd == `AMC_OP_SETMULT) && (tf.secCount == 8'h00) |=> !multiEnable && !errAbort;
    endproperty
    a_multi_zero: assert property (p_multi_zero) else $error("zero count enabled"); // RULE_04

    property p_sleep_cmd;
        exec && isSleepOp(cmd) |=> sleepMode && !busy && intStat.done;
    endproperty
    a_sleep_cmd: assert property (p_sleep_cmd) else $error("sleep command failed"); // RULE_06

    property p_wake;
        cmdTake |=> !sleepMode;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on command"); // RULE_07

    property p_idle_sleep;
        ce && idleExpire && !cmdTake |=> sleepMode;
    endproperty
    a_idle_sleep: assert property (p_idle_sleep) else $error("timer did not sleep"); // RULE_08

    property p_nop_count;
        exec && ((cmd == `AMC_OP_XLATE) || (cmd == `AMC_OP_WEAR)) |=> tf.secCount == 8'h00;
    endproperty
    a_nop_count: assert property (p_nop_count) else $error("count not zeroed"); // RULE_12

    property p_wbuf_end;
        lastWord |=> !drq && !busy && (state == AMC_IDLE) && intStat.bufFull;
    endproperty
    a_wbuf_end: assert property (p_wbuf_end) else $error("buffer end wrong"); // RULE_14

    property p_ignore_other;
        cmdWr && (state == AMC_IDLE) && !devMatch |=> (state == AMC_IDLE) && !busy;
    endproperty
    a_ignore_other: assert property (p_ignore_other) else $error("other drive taken"); // RULE_15

    c_multi_ok: cover property (exec && (cmd == `AMC_OP_SETMULT) && !next_abort && next_multi);
    c_sleep: cover property (exec && goSleep);
    c_wbuf: cover property (lastWord);
    c_irq: cover property ($rose(irq));
endmodule

// [hw/amc_params.svh]
// Constants of the miscellaneous task-file command handler.
// How it works
// RULE_01: Set-multiple opcode raises busy, then checks the sector count as block size.
// RULE_02: A supported nonzero block count is stored and enables multi-sector commands.
// RULE_03: An unsupported block count aborts and disables multi-sector commands.
// RULE_04: Set-multiple with sector count zero leaves multi-sector commands disabled.
// RULE_05: Multi-sector commands are disabled after power-on.
// RULE_06: Sleep opcodes raise busy, enter sleep, drop busy, raise an interrupt.
// RULE_07: Any new command wakes the device; no separate wake sequence exists.
// RULE_08: Idle timer enters sleep after 20 ms, counted in 5 ms ticks.
// RULE_09: Monitoring command needs signature in cylinder high; identify word 82 bit 0 set.
// RULE_10: Standby opcodes raise busy, enter sleep, drop busy, interrupt at once.
// RULE_11: Standby-immediate opcodes do the same with no delay.
// RULE_12: Translate sector is a no-operation leaving sector count zero.
// RULE_13: Wear level is a no-operation returning zero in sector count.
// RULE_14: Write buffer takes exactly 512 bytes into the sector buffer unchanged.
// RULE_15: Unused fields are ignored; only drive select and defined fields decode.
`ifndef AMC_PARAMS_SVH
`define AMC_PARAMS_SVH
`define AMC_A_DATA     4'h0
`define AMC_A_FEAT     4'h1
`define AMC_A_SECCNT   4'h2
`define AMC_A_SECNUM   4'h3
`define AMC_A_CYLLO    4'h4
`define AMC_A_CYLHI    4'h5
`define AMC_A_DRVHD    4'h6
`define AMC_A_CMD      4'h7
`define AMC_A_INTSTAT  4'h8
`define AMC_A_INTMASK  4'h9
`define AMC_A_MULTI    4'hA
`define AMC_A_IDENT82  4'hB
`define AMC_OP_SETMULT 8'hC6
`define AMC_OP_SLEEP_A 8'h99
`define AMC_OP_SLEEP_B 8'hE6
`define AMC_OP_STBY_A  8'h96
`define AMC_OP_STBY_B  8'hE2
`define AMC_OP_STBI_A  8'h94
`define AMC_OP_STBI_B  8'hE0
`define AMC_OP_SMART   8'hB0
`define AMC_OP_XLATE   8'h87
`define AMC_OP_WEAR    8'hF5
`define AMC_OP_WBUF    8'hE8
`define AMC_SMART_HI   8'hC2
`define AMC_SMART_LO   8'h4F
`define AMC_DH_DEV     4
`define AMC_ERR_ABRT   2
`define AMC_IDENT82    16'h0001
`define AMC_CLK_NS     10
`define AMC_TICK_MS    5
`define AMC_IDLE_MS    20
`define AMC_TICK_CYC   ((`AMC_TICK_MS * 1000000) / `AMC_CLK_NS)
`define AMC_IDLE_TICKS (`AMC_IDLE_MS / `AMC_TICK_MS)
`define AMC_BUF_WORDS  256
`endif

// [hw/amc_pkg.sv]
// Types shared by the command handler files.
package amc_pkg;
    typedef enum logic [1:0] {
        AMC_IDLE = 2'b00,
        AMC_EXEC = 2'b01,
        AMC_XFER = 2'b10
    } amc_state_t;
    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] secCount;
        logic [7:0] secNum;
        logic [7:0] cylLow;
        logic [7:0] cylHigh;
        logic [7:0] driveHead;
    } amc_taskfile_t;
    typedef struct packed {
        logic bufFull;
        logic sleep;
        logic abort;
        logic done;
    } amc_events_t;
endpackage

// [hw/amc_sector_mem.sv]
// Sector buffer memory with a registered read port.
`timescale 1ns/1ns
module amc_sector_mem #(
    parameter int DW    = 16,
    parameter int DEPTH = 256,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          ref_clk,
    input  wire logic          ce,
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [DW-1:0] wrData,
    input  wire logic [AW-1:0] rdAddr,
    output logic      [DW-1:0] rdData
);
    logic [DW-1:0] mem [DEPTH];

    // Stores written words and reads one word every enabled cycle.
    always_ff @(posedge ref_clk) begin
        if (ce) begin
            if (wrEn) begin
                mem[wrAddr] <= wrData;
            end
            rdData <= mem[rdAddr];
        end
    end
endmodule

// [hw/amc_idle_timer.sv]
// Idle timer that counts a prescaled time base and pulses on expiry.
`timescale 1ns/1ns
module amc_idle_timer #(
    parameter int TICK_CYCLES = 500000,
    parameter int IDLE_TICKS  = 4
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic ce,
    input  wire logic restart,
    input  wire logic run,
    output logic      expire
);
    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam int TW = $clog2(IDLE_TICKS + 1);
    logic [PW-1:0] preCnt;
    logic [TW-1:0] tickCnt;
    logic          tick;

    assign tick = (preCnt == PW'(TICK_CYCLES - 1));

    // Counts ticks while idle and fires once per idle period.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            preCnt  <= '0;
            tickCnt <= '0;
            expire  <= 1'b0;
        end else if (ce) begin
            expire <= 1'b0;
            if (restart || !run) begin
                preCnt  <= '0;
                tickCnt <= '0;
            end else if (tickCnt != TW'(IDLE_TICKS)) begin
                preCnt <= tick ? '0 : preCnt + 1'b1;
                if (tick) begin
                    tickCnt <= tickCnt + 1'b1;
                    expire  <= (tickCnt == TW'(IDLE_TICKS - 1)); // RULE_08
                end
            end
        end
    end
endmodule

// [tb/amc_host_model.sv]
// Host controller model that drives the task-file register port.
`timescale 1ns/1ns
module amc_host_model (
    input  wire logic        ref_clk,
    output logic      [3:0]  addr,
    output logic      [15:0] wrData,
    output logic             wrStb,
    output logic             rdStb,
    input  wire logic [15:0] rdData
);
    ////////////////////////////////////////////////////////////////////////////////
    // The bus starts quiet so that no strobe is seen before reset ends.
    initial begin
        addr   = 4'h0;
        wrData = 16'h0000;
        wrStb  = 1'b0;
        rdStb  = 1'b0;
    end

    // One write cycle; the data lines are inverted on release so stale data never match.
    task automatic wr(input logic [3:0] a, input logic [15:0] dat);
        @(posedge ref_clk);
        addr   <= a;
        wrData <= dat;
        wrStb  <= 1'b1;
        @(posedge ref_clk);
        wrStb  <= 1'b0;
        wrData <= ~dat;
        #1;
    endtask

    // One read cycle; the answer stands only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [15:0] dat);
        @(posedge ref_clk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge ref_clk);
        rdStb <= 1'b0;
        #1;
        dat = rdData;
    endtask
endmodule

// [tb/tb_top.sv]
// Self-checking testbench of the task-file command handler.
`timescale 1ns/1ns
`include "amc_params.svh"
module tb_top import amc_pkg::*;;
    localparam int TICKS = 4;
    localparam int IDLE  = 2;
    logic        ref_clk;
    logic        rst_b;
    logic        ce;
    logic [3:0]  addr;
    logic [15:0] wrData;
    logic [15:0] rdData;
    logic [15:0] d;
    logic        wrStb;
    logic        rdStb;
    logic        irq;
    logic        busy;
    logic        drq;
    logic        sleepMode;
    logic        multiEnable;
    int          errors;
    int          n_tests;
    int          n;
    logic [7:0]  cnt [3] = '{8'h01, 8'h02, 8'h00};
    logic [15:0] msk [3] = '{16'hFFFF, 16'h0100, 16'h0100};
    logic [15:0] mx  [3] = '{16'h0101, 16'h0000, 16'h0000};
    logic [15:0] ab  [3] = '{16'h0000, 16'h0004, 16'h0000};
    logic [7:0]  ops [6] = '{`AMC_OP_SLEEP_A, `AMC_OP_SLEEP_B, `AMC_OP_STBY_A,
                            `AMC_OP_STBY_B, `AMC_OP_STBI_A, `AMC_OP_STBI_B};

    ////////////////////////////////////////////////////////////////////////////////
    // Clock of 10 ns period.
    always #5 ref_clk = ~ref_clk;

    // Short timer counts keep the idle sleep test fast.
    amc_cmd_handler #(.TICK_CYCLES(TICKS), .IDLE_TICKS(IDLE)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq), .busy(busy),
        .drq(drq), .sleepMode(sleepMode), .multiEnable(multiEnable));

    amc_host_model host (
        .ref_clk(ref_clk), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData));

    ////////////////////////////////////////////////////////////////////////////////
    // Compares one value and counts it.
    task automatic check(input logic [15:0] s, input logic [15:0] e, input string m);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, m, s, e);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Moves one cycle on, past the edge's updates.
    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask

    // Writes one opcode to the command register.
    task automatic cmd(input logic [7:0] op);
        host.wr(`AMC_A_CMD, {8'h00, op});
    endtask

    // Buffer pattern that differs in every word.
    function automatic logic [15:0] pat(input int i);
        return {8'(i), ~8'(i)};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // A hang anywhere is cut short here.
    initial begin
        #200000;
        errors++;
        $display("mismatch at %0t: run timed out", $time);
        end_sim();
    end

    // Main sequence of tests.
    initial begin
        ref_clk = 1'b0;
        rst_b   = 1'b0;
        ce      = 1'b1;
        errors  = 0;
        n_tests = 0;
        repeat (5) @(posedge ref_clk);
        check(16'({busy, drq, sleepMode, multiEnable, irq}), 16'h0000, "reset");
        rst_b <= 1'b1;
        host.rd(`AMC_A_MULTI, d);
        check(d, 16'h0000, "multi after reset");
        host.rd(`AMC_A_IDENT82, d);
        check(d, `AMC_IDENT82, "identify word");
        host.rd(4'hC, d);
        check(d, 16'h0000, "unmapped read");
        $display("test reset done");
        // Junk in fields that set multiple does not use.
        host.wr(`AMC_A_FEAT, 16'h00FF);
        host.wr(`AMC_A_CYLHI, 16'h00AA);
        host.wr(`AMC_A_DRVHD, 16'h00EF);
        host.wr(`AMC_A_INTMASK, 16'h000F);
        for (int k = 0; k < 3; k++) begin
            host.wr(`AMC_A_SECCNT, {8'h00, cnt[k]});
            cmd(`AMC_OP_SETMULT);
            check(16'(busy), 16'h0001, "busy on set multiple");
            step;
            check(16'(multiEnable), mx[k] >> 8, "multi enable");
            host.rd(`AMC_A_MULTI, d);
            check(d & msk[k], mx[k], "multi register");
            host.rd(`AMC_A_FEAT, d);
            check(d & 16'h0004, ab[k], "abort flag");
        end
        check(16'(irq), 16'h0001, "irq unmasked");
        host.wr(`AMC_A_INTSTAT, 16'h000F);
        step;
        check(16'(irq), 16'h0000, "irq cleared");
        host.wr(`AMC_A_INTMASK, 16'h0000);
        cmd(`AMC_OP_XLATE);
        repeat (2) step;
        check(16'(irq), 16'h0000, "irq masked");
        host.rd(`AMC_A_INTSTAT, d);
        check(d & 16'h0001, 16'h0001, "done sticky");
        $display("test set multiple done");
        // Wrong drive select: the command is not taken.
        host.wr(`AMC_A_DRVHD, 16'h0010);
        cmd(`AMC_OP_SLEEP_A);
        check(16'({busy, sleepMode}), 16'h0000, "other drive ignored");
        host.wr(`AMC_A_DRVHD, 16'h0000);
        host.wr(`AMC_A_INTMASK, 16'h0004);
        host.wr(`AMC_A_INTSTAT, 16'h000F);
        foreach (ops[k]) begin
            cmd(ops[k]);
            check(16'({busy, sleepMode}), 16'h0002, "busy and awake");
            step;
            check(16'({busy, sleepMode}), 16'h0001, "asleep");
            host.rd(`AMC_A_INTSTAT, d);
            check(d, 16'h0005, "sleep events");
            check(16'(irq), 16'h0001, "sleep irq");
            host.wr(`AMC_A_INTSTAT, 16'h000F);
        end
        $display("test sleep done");
        foreach (ops[k]) begin
            if (k < 2) begin
                host.wr(`AMC_A_SECCNT, 16'h0055);
                cmd(k == 0 ? `AMC_OP_XLATE : `AMC_OP_WEAR);
                step;
                host.rd(`AMC_A_SECCNT, d);
                check(d, 16'h0000, "no-op sector count");
                host.wr(`AMC_A_CYLHI, k == 0 ? {8'h00, `AMC_SMART_HI} : 16'h0000);
                host.wr(`AMC_A_CYLLO, {8'h00, `AMC_SMART_LO});
                cmd(`AMC_OP_SMART);
                step;
                host.rd(`AMC_A_FEAT, d);
                check(d & 16'h0004, k == 0 ? 16'h0000 : 16'h0004, "signature");
            end
        end
        cmd(8'hFF);
        step;
        host.rd(`AMC_A_FEAT, d);
        check(d & 16'h0004, 16'h0004, "unknown opcode aborts");
        $display("test no-op and monitor done");
        cmd(`AMC_OP_XLATE);
        step;
        n = 0;
        while (sleepMode !== 1'b1 && n < 40) begin
            step;
            n++;
        end
        check(16'(n >= TICKS * IDLE - 4 && n <= TICKS * IDLE + 1), 16'h0001, "idle time");
        $display("test idle timer done");
        cmd(`AMC_OP_WBUF);
        step;
        for (int i = 0; i < 256; i++) begin
            check(16'(drq), 16'h0001, "data expected");
            host.wr(`AMC_A_DATA, pat(i));
        end
        check(16'(drq), 16'h0000, "512 bytes end transfer");
        host.rd(`AMC_A_INTSTAT, d);
        check(d & 16'h0008, 16'h0008, "buffer full event");
        cmd(`AMC_OP_XLATE);
        step;
        for (int i = 0; i < 4; i++) begin
            host.rd(`AMC_A_DATA, d);
            check(d, pat(i), "buffer word");
        end
        $display("test write buffer done");
        end_sim();
    end
endmodule
